// ===== core/fsa_flash_guard.sv
// flash sector access guard: bus registers, mode checks, protection, link
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns

// Notes on behaviour
// - flash erases as whole block or per sector; programs one byte each.
// - in a programming tool every sector and option bytes are writable.
// - board-level programming allows every sector and option bytes.
// - self-programming may write every sector except sector 0.
// - sector count follows flash size: one, two or three sectors.
// - each sector erases alone; other sectors stay untouched.
// - sectors 0 and 1 are 4 KB at the top; sector 0 is F000-FFFF.
// - read-out protection blocks external extraction and all flash writes except the request that lifts protection.
// - removing protection first erases the whole flash, then reprograms.
// - protection follows only the dedicated option byte bit.
// - low voltage detector is off while read-out protection holds.
// - link uses four to six connections; clock and supply optional.
// - serial data is bidirectional, clock has its own connection.
// - an access guard sequence must precede every program or erase.
// - test mode lets user patterns run from RAM.
module fsa_flash_guard
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire fsa_pkg::fsa_axil_req_t  axi_req,
  output fsa_pkg::fsa_axil_rsp_t       axi_rsp,
  output fsa_pkg::fsa_flash_req_t      flash_req,
  input  wire logic                    flash_done,
  input  wire logic                    readout_protect_option_bit,
  input  wire logic                    tool_socket_present,
  input  wire logic                    program_voltage_select,
  input  wire logic                    incircuit_serial_clock,
  input  wire logic                    incircuit_serial_data_in,
  output logic                         incircuit_serial_data_out,
  output logic                         incircuit_serial_data_oe,
  output logic                         board_level_programming,
  output logic                         self_programming,
  output logic                         incircuit_test_mode,
  output logic                         low_voltage_detector_en,
  output logic                         readout_block
);
  import fsa_pkg::*;

  // ==========================================================================
  // state of the bus clock domain
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OPTION} fsa_state_t;

  typedef struct packed {
    logic [1:0]     opt_sync;
    logic [1:0]     tool_sync;
    logic [1:0]     vpp_sync;
    logic [2:0]     evt_sync;
    logic [1:0]     init_cnt;
    logic           strap_taken;
    logic           protect;
    logic           board_mode;
    logic           test_mode;
    logic           key1_seen;
    logic           armed;
    logic           done;
    logic           refused;
    fsa_state_t     state;
    logic           opt_pending;
    logic           opt_value;
    fsa_ctrl_t      ctrl;
    logic [15:0]    addr;
    logic [7:0]     wdata;
    fsa_flash_req_t flash;
    logic           aw_ok;
    logic [11:0]    awaddr;
    logic           w_ok;
    logic [31:0]    wbuf;
    logic [3:0]     wstrb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } fsa_core_t;

  // protection defaults on until the strap has been read
  localparam fsa_core_t CORE_RESET = '{protect: 1'b1, state: ST_IDLE, default: '0};

  // ==========================================================================
  // state of the link clock domain
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [7:0] st_s1;
    logic [7:0] st_s2;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [2:0] cnt;
    logic       talking;
    logic       evt_tog;
    logic [7:0] evt_code;
  } fsa_link_t;

  fsa_core_t   s;
  fsa_core_t   n;
  fsa_link_t   l;
  fsa_link_t   ln;
  fsa_mode_t   mode;
  fsa_status_t status;
  fsa_ctrl_t   wctrl;
  logic [31:0] wmerged;
  logic [1:0]  addr_sector;
  logic        addr_in_flash;
  logic        link_event;
  logic        do_write;
  logic [11:0] waddr_al;
  logic [11:0] raddr_al;
  logic        status_clr_done;
  logic        status_clr_refused;
  logic        set_done;
  logic        set_refused;
  logic [1:0]  req_sector;
  logic        req_legal;
  logic [7:0]  link_status;

  // byte-lane merge of write data over an old register value
  function automatic logic [31:0] fsa_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // mode and address decode
  // tool socket wins over any link request
  assign mode = s.tool_sync[1] ? MODE_TOOL : (s.board_mode ? MODE_BOARD : MODE_SELF);

  // top two sectors are fixed 4 KB windows under the vectors
  always_comb
  begin
    addr_in_flash = ({1'b0, s.addr} >= FLASH_BASE);
    if (s.addr >= SECTOR0_BASE)
    begin
      addr_sector = SECTOR_0;
    end
    else if (s.addr >= SECTOR1_BASE)
    begin
      addr_sector = SECTOR_1;
    end
    else
    begin
      addr_sector = SECTOR_2;
    end
  end

  // status word shown to software and, in part, to the link
  always_comb
  begin
    status            = '0;
    status.busy       = (s.state != ST_IDLE);
    status.done       = s.done;
    status.refused    = s.refused;
    status.armed      = s.armed;
    status.mode       = mode;
    status.protect    = s.protect;
    status.lvd_enable = low_voltage_detector_en;
    status.test_mode  = s.test_mode;
  end

  assign link_status = status[7:0];

  // ==========================================================================
  // bus domain next state
  assign waddr_al   = {s.awaddr[11:2], 2'b00};
  assign raddr_al   = {axi_req.araddr[11:2], 2'b00};
  assign do_write   = s.aw_ok && s.w_ok && !s.bvalid;
  assign link_event = s.evt_sync[2] ^ s.evt_sync[1];
  assign wmerged    = fsa_merge(32'h0000_0000, s.wbuf, s.wstrb);
  assign wctrl      = fsa_ctrl_t'(wmerged);

  // legality of the control word being written
  always_comb
  begin
    req_sector = (wctrl.op == CTRL_OP_PROG) ? addr_sector : wctrl.sector;
    req_legal  = 1'b1;
    // sectors beyond the fitted size do not exist
    if (32'(req_sector) >= 32'(SECTOR_COUNT))
    begin
      req_legal = 1'b0;
    end
    if ((wctrl.op == CTRL_OP_PROG) && !addr_in_flash)
    begin
      req_legal = 1'b0;
    end
    // self-programming never touches sector 0 or the whole array
    if ((mode == MODE_SELF) &&
        ((req_sector == SECTOR_0) || (wctrl.op == CTRL_OP_ERALL) || wctrl.opt_write))
    begin
      req_legal = 1'b0;
    end
    // nothing starts without the armed guard
    if (!s.armed || (s.state != ST_IDLE) || !s.vpp_sync[1])
    begin
      req_legal = 1'b0;
    end
    // protection refuses writes, except lifting the protection itself
    if (s.protect && !(wctrl.opt_write && !wctrl.opt_value))
    begin
      req_legal = 1'b0;
    end
  end

  always_comb
  begin
    n                  = s;
    n.flash.valid      = 1'b0;
    set_done           = 1'b0;
    set_refused        = 1'b0;
    status_clr_done    = 1'b0;
    status_clr_refused = 1'b0;

    // pins pass two flip-flops before use
    n.opt_sync  = {s.opt_sync[0], readout_protect_option_bit};
    n.tool_sync = {s.tool_sync[0], tool_socket_present};
    n.vpp_sync  = {s.vpp_sync[0], program_voltage_select};
    n.evt_sync  = {s.evt_sync[1:0], l.evt_tog};

    // strap caught once after reset release, then frozen
    if (!s.strap_taken)
    begin
      n.init_cnt = s.init_cnt + 2'h1;
      if (s.init_cnt == STRAP_DELAY)
      begin
        n.strap_taken = 1'b1;
        // protection set only by the option bit
        n.protect     = s.opt_sync[1];
      end
    end

    // link commands switch the operating mode
    if (link_event)
    begin
      unique case (l.evt_code)
        LINK_CMD_ENTER: n.board_mode = 1'b1;
        // test mode hands the core over to patterns in RAM
        LINK_CMD_TEST:  n.test_mode  = 1'b1;
        LINK_CMD_LEAVE:
        begin
          n.board_mode = 1'b0;
          n.test_mode  = 1'b0;
        end
        default: ;
      endcase
    end

    // write address and data are taken independently
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      n.aw_ok  = 1'b1;
      n.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      n.w_ok  = 1'b1;
      n.wbuf  = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
    end
    if (s.bvalid && axi_req.bready)
    begin
      n.bvalid = 1'b0;
    end

    // register write once both halves are in
    if (do_write)
    begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      unique case (waddr_al)
        REG_CTRL:
        begin
          n.ctrl  = wctrl;
          // guard is spent by any control write, legal or not
          n.armed = 1'b0;
          if ((wctrl.op != CTRL_OP_NONE) || wctrl.opt_write)
          begin
            // refused requests never reach the flash port
            if (!req_legal)
            begin
              set_refused = 1'b1;
            end
            // unprotect wipes the whole array before the option
            else if (wctrl.opt_write && s.protect)
            begin
              n.flash.valid  = 1'b1;
              n.flash.op     = FOP_ERASE_ALL;
              n.opt_pending  = 1'b1;
              n.opt_value    = wctrl.opt_value;
              n.state        = ST_WAIT;
            end
            // board and tool modes reach the option byte
            else if (wctrl.opt_write)
            begin
              n.flash.valid     = 1'b1;
              n.flash.op        = FOP_WRITE_OPTION;
              n.flash.opt_value = wctrl.opt_value;
              n.state           = ST_WAIT;
            end
            else
            begin
              // byte program, sector erase or whole-block erase
              n.flash.valid  = 1'b1;
              n.flash.sector = req_sector;
              n.flash.addr   = s.addr;
              n.flash.data   = s.wdata;
              n.state        = ST_WAIT;
              unique case (wctrl.op)
                CTRL_OP_PROG:  n.flash.op = FOP_PROGRAM;
                // a sector erase names one sector only
                CTRL_OP_ERASE: n.flash.op = FOP_ERASE_SECTOR;
                default:       n.flash.op = FOP_ERASE_ALL;
              endcase
            end
          end
        end
        REG_GUARD:
        begin
          // two keys in a row arm exactly one command
          if (wmerged[7:0] == GUARD_KEY1)
          begin
            n.key1_seen = 1'b1;
          end
          else
          begin
            n.key1_seen = 1'b0;
            if (s.key1_seen && (wmerged[7:0] == GUARD_KEY2))
            begin
              n.armed = 1'b1;
            end
          end
        end
        REG_ADDR:   n.addr  = 16'(fsa_merge({16'h0000, s.addr}, s.wbuf, s.wstrb));
        REG_WDATA:  n.wdata = 8'(fsa_merge({24'h000000, s.wdata}, s.wbuf, s.wstrb));
        REG_STATUS:
        begin
          status_clr_done    = wmerged[1];
          status_clr_refused = wmerged[2];
        end
        default:    n.bresp = RESP_SLVERR;
      endcase
    end

    // flash operation engine
    unique case (s.state)
      ST_IDLE: ;
      ST_WAIT:
      begin
        if (flash_done)
        begin
          if (s.opt_pending)
          begin
            n.state = ST_OPTION;
          end
          else
          begin
            n.state  = ST_IDLE;
            set_done = 1'b1;
          end
        end
      end
      ST_OPTION:
      begin
        // option reprogrammed only after the full erase finished
        n.flash.valid     = 1'b1;
        n.flash.op        = FOP_WRITE_OPTION;
        n.flash.opt_value = s.opt_value;
        n.opt_pending     = 1'b0;
        n.state           = ST_WAIT;
      end
      default: n.state = ST_IDLE;
    endcase

    // sticky flags: a set in the same cycle beats the clear
    n.done    = set_done    | (s.done    & ~status_clr_done);
    n.refused = set_refused | (s.refused & ~status_clr_refused);

    // read channel, one word per request
    if (s.rvalid && axi_req.rready)
    begin
      n.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      unique case (raddr_al)
        REG_CTRL:   n.rdata = s.ctrl;
        REG_GUARD:  n.rdata = {31'h0000_0000, s.armed};
        REG_ADDR:   n.rdata = {16'h0000, s.addr};
        REG_WDATA:  n.rdata = {24'h000000, s.wdata};
        REG_STATUS: n.rdata = status;
        default:
        begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // bus domain registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= CORE_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  // ==========================================================================
  // bus outputs; ready is combinational, answers come from flip-flops
  always_comb
  begin
    axi_rsp         = '0;
    axi_rsp.awready = !s.aw_ok && !s.bvalid;
    axi_rsp.wready  = !s.w_ok && !s.bvalid;
    axi_rsp.bvalid  = s.bvalid;
    axi_rsp.bresp   = s.bresp;
    axi_rsp.arready = !s.rvalid;
    axi_rsp.rvalid  = s.rvalid;
    axi_rsp.rdata   = s.rdata;
    axi_rsp.rresp   = s.rresp;
  end

  assign flash_req               = s.flash;
  assign board_level_programming = (mode == MODE_BOARD);
  assign self_programming        = (mode == MODE_SELF);
  assign incircuit_test_mode     = s.test_mode;
  // detector held off while protection is in force
  assign low_voltage_detector_en = s.strap_taken && !s.protect;
  // external reads are cut off when protected and an outside party rules
  assign readout_block           = s.protect && (mode != MODE_SELF);

  // ==========================================================================
  // link domain: serial clock on its own port, data pin turned around
  // data is sampled while listening and driven only while answering
  always_comb
  begin
    ln          = l;
    ln.rst_sync = {l.rst_sync[0], 1'b1};
    // status bits are quasi-static levels, a torn byte only misreports once
    ln.st_s1    = link_status;
    ln.st_s2    = l.st_s1;
    if (!l.rst_sync[1])
    begin
      ln.rx_sh   = '0;
      ln.tx_sh   = '0;
      ln.cnt     = '0;
      ln.talking = 1'b0;
    end
    else if (l.talking)
    begin
      ln.tx_sh = {l.tx_sh[6:0], 1'b0};
      ln.cnt   = l.cnt + 3'h1;
      if (l.cnt == 3'h7)
      begin
        ln.talking = 1'b0;
      end
    end
    else
    begin
      ln.rx_sh = {l.rx_sh[6:0], incircuit_serial_data_in};
      ln.cnt   = l.cnt + 3'h1;
      if (l.cnt == 3'h7)
      begin
        if ({l.rx_sh[6:0], incircuit_serial_data_in} == LINK_CMD_STATUS)
        begin
          ln.talking = 1'b1;
          ln.tx_sh   = l.st_s2;
        end
        else
        begin
          // code is held steady until the bus side has seen the toggle
          ln.evt_code = {l.rx_sh[6:0], incircuit_serial_data_in};
          ln.evt_tog  = ~l.evt_tog;
        end
      end
    end
  end

  // link registers; aresetn clears them on a serial clock edge, the local reset synchroniser only delays release
  always_ff @(posedge incircuit_serial_clock)
  begin
    if (!aresetn)
    begin
      l <= '0;
    end
    else
    begin
      l <= ln;
    end
  end

  assign incircuit_serial_data_out = l.tx_sh[7];
  assign incircuit_serial_data_oe  = l.talking;
endmodule

// ===== core/fsa_pkg.sv
// shared constants, types and register layout of the flash sector access guard
package fsa_pkg;

  // ==========================================================================
  // flash geometry
  localparam int          FLASH_SIZE_KB = 60;
  localparam int          SECTOR_KB     = 4;
  localparam int          SECTOR_COUNT  = (FLASH_SIZE_KB > 8) ? 3 :
                                          ((FLASH_SIZE_KB > 4) ? 2 : 1);
  localparam logic [15:0] SECTOR0_BASE  = 16'hf000;   // vectors live here
  localparam logic [15:0] SECTOR1_BASE  = 16'he000;
  localparam logic [16:0] FLASH_BASE    = 17'h10000 - 17'(FLASH_SIZE_KB * 1024);
  localparam logic [1:0]  SECTOR_0      = 2'h0;
  localparam logic [1:0]  SECTOR_1      = 2'h1;
  localparam logic [1:0]  SECTOR_2      = 2'h2;

  // ==========================================================================
  // register byte offsets on the bus
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_GUARD  = 12'h004;
  localparam logic [11:0] REG_ADDR   = 12'h008;
  localparam logic [11:0] REG_WDATA  = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // register access guard keys, written in this order to arm one command
  localparam logic [7:0]  GUARD_KEY1 = 8'h56;
  localparam logic [7:0]  GUARD_KEY2 = 8'hae;

  // control register operation codes
  localparam logic [1:0]  CTRL_OP_NONE   = 2'h0;
  localparam logic [1:0]  CTRL_OP_PROG   = 2'h1;
  localparam logic [1:0]  CTRL_OP_ERASE  = 2'h2;
  localparam logic [1:0]  CTRL_OP_ERALL  = 2'h3;

  // link command bytes
  localparam logic [7:0]  LINK_CMD_ENTER  = 8'h01;
  localparam logic [7:0]  LINK_CMD_TEST   = 8'h02;
  localparam logic [7:0]  LINK_CMD_STATUS = 8'h03;
  localparam logic [7:0]  LINK_CMD_LEAVE  = 8'h04;

  // cycles after reset release before the option strap is trusted
  localparam logic [1:0]  STRAP_DELAY = 2'h2;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    FOP_PROGRAM      = 2'h0,
    FOP_ERASE_SECTOR = 2'h1,
    FOP_ERASE_ALL    = 2'h2,
    FOP_WRITE_OPTION = 2'h3
  } fsa_fop_t;

  typedef enum logic [1:0] {
    MODE_SELF  = 2'h0,
    MODE_BOARD = 2'h1,
    MODE_TOOL  = 2'h2
  } fsa_mode_t;

  // ==========================================================================
  // register layouts
  typedef struct packed {
    logic [22:0] rsv_hi;
    logic        opt_value;   // new read-out protection value
    logic        opt_write;   // program the option byte
    logic [2:0]  rsv_lo;
    logic [1:0]  sector;
    logic [1:0]  op;
  } fsa_ctrl_t;

  typedef struct packed {
    logic [22:0] rsv;
    logic        test_mode;
    logic        lvd_enable;
    logic        protect;
    fsa_mode_t   mode;
    logic        armed;
    logic        refused;
    logic        done;
    logic        busy;
  } fsa_status_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } fsa_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fsa_axil_rsp_t;

  typedef struct packed {
    logic        valid;
    fsa_fop_t    op;
    logic [1:0]  sector;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        opt_value;
  } fsa_flash_req_t;

endpackage

// ===== verification/fsa_flash_guard_tb.sv
// self-checking bench for the flash sector access guard
`timescale 1ns/1ns
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module fsa_flash_guard_tb;
  import fsa_pkg::*;
  fsa_axil_req_t  q;
  fsa_axil_rsp_t  s;
  fsa_flash_req_t fr, last;
  logic aclk = 0, aresetn = 0, prot = 0, sock = 0, vpp = 1;
  logic fdone, lclk, ldat, dout, doe, line, bl, sp, tm, low_voltage_detector, rb;
  logic [31:0] st;
  logic [7:0]  rx;
  logic [1:0]  rr;
  int n_errors = 0, total_checks = 0, n_fl = 0, cyc = 0;
  assign line = doe ? dout : ldat;
  always #5 aclk = ~aclk;
  fsa_flash_guard u_fsa_flash_guard (.aclk(aclk), .aresetn(aresetn), .axi_req(q),
    .axi_rsp(s), .flash_req(fr), .flash_done(fdone), .readout_protect_option_bit(prot),
    .tool_socket_present(sock), .program_voltage_select(vpp), .incircuit_serial_clock(lclk),
    .incircuit_serial_data_in(line), .incircuit_serial_data_out(dout),
    .incircuit_serial_data_oe(doe), .board_level_programming(bl), .self_programming(sp),
    .incircuit_test_mode(tm), .low_voltage_detector_en(low_voltage_detector), .readout_block(rb));
  fsa_tool_model u_fsa_tool_model (.aclk(aclk), .flash_go(fr.valid), .flash_done(fdone),
    .lclk(lclk), .ldat(ldat), .dev_oe(doe), .line(line));
  // ==========================================================================
  // command log and hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (fr.valid === 1'b1)
    begin
      n_fl++;
      last = fr;
    end
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // write: address and data together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    q.awaddr <= a; q.wdata <= d; q.wstrb <= 4'hf;
    q.awvalid <= 1'b1; q.wvalid <= 1'b1; q.bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s.awready) q.awvalid <= 1'b0;
      if (s.wready) q.wvalid <= 1'b0;
    end while (s.bvalid !== 1'b1);
    rr = s.bresp;
    q.bready <= 1'b0;
  endtask
  // read: rready a cycle late to exercise the held answer
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    q.araddr <= a; q.arvalid <= 1'b1;
    do @(posedge aclk); while (s.arready !== 1'b1);
    q.arvalid <= 1'b0;
    @(posedge aclk);
    q.rready <= 1'b1;
    do @(posedge aclk); while (s.rvalid !== 1'b1);
    st = s.rdata; rr = s.rresp;
    q.rready <= 1'b0;
  endtask
  // guarded command, wait idle, check pulses and flags
  task automatic fc(input logic [31:0] c, input logic arm, input int npl);
    int n0;
    n0 = n_fl;
    if (arm)
    begin
      wr(REG_GUARD, 32'(GUARD_KEY1));
      wr(REG_GUARD, 32'(GUARD_KEY2));
    end
    wr(REG_CTRL, c);
    do rd(REG_STATUS); while (st[0] !== 1'b0);
    `CK(n_fl - n0, npl)
    `CK(st[2:1], (npl > 0) ? 2'b01 : 2'b10)
    wr(REG_STATUS, 32'h6);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    fork
      u_fsa_tool_model.rst_edges(4);
      repeat (4) @(posedge aclk);
    join
    aresetn <= 1'b1;
    u_fsa_tool_model.rst_edges(2);
    repeat (6) @(posedge aclk);
  endtask
  // ==========================================================================
  // main sequence
  initial
  begin
    q = '0;
    do_reset();
    rd(REG_STATUS); `CK(st[8:4], 5'h08)
    `CK(low_voltage_detector, 1'b1)
    rd(12'h020); `CK(rr, RESP_SLVERR)
    fc(32'h6, 1'b0, 0);
    fc(32'h2, 1'b1, 0);
    wr(REG_ADDR, 32'hf010); fc(32'h1, 1'b1, 0);
    fc(32'h6, 1'b1, 1); `CK(last.sector, SECTOR_1)
    wr(REG_ADDR, 32'he010); wr(REG_WDATA, 32'h5a); fc(32'h1, 1'b1, 1);
    `CK({last.op, last.addr, last.data}, {FOP_PROGRAM, 16'he010, 8'h5a})
    u_fsa_tool_model.xfer(LINK_CMD_ENTER, rx); repeat (10) @(posedge aclk);
    `CK(bl, 1'b1)
    u_fsa_tool_model.xfer(LINK_CMD_STATUS, rx); u_fsa_tool_model.xfer(8'h00, rx);
    `CK(rx[5:4], MODE_BOARD)
    fc(32'h2, 1'b1, 1); `CK(last.sector, SECTOR_0)
    fc(32'h3, 1'b1, 1); `CK(last.op, FOP_ERASE_ALL)
    u_fsa_tool_model.xfer(LINK_CMD_TEST, rx); repeat (10) @(posedge aclk);
    `CK(tm, 1'b1)
    u_fsa_tool_model.xfer(LINK_CMD_LEAVE, rx); repeat (10) @(posedge aclk);
    `CK({tm, sp}, 2'b01)
    sock <= 1'b1; repeat (6) @(posedge aclk);
    fc(32'h2, 1'b1, 1);
    fc(32'h180, 1'b1, 1); `CK(last.op, FOP_WRITE_OPTION)
    prot <= 1'b1; do_reset();
    `CK({rb, low_voltage_detector}, 2'b10)
    fc(32'h6, 1'b1, 0);
    prot <= 1'b0; repeat (8) @(posedge aclk);
    `CK(rb, 1'b1)
    fc(32'h080, 1'b1, 2); `CK(last.opt_value, 1'b0)
    final_report();
  end
endmodule

// ===== verification/fsa_guard_chk.sv
// assertion checker watching the flash sector access guard ports
`timescale 1ns/1ns
module fsa_guard_chk
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire fsa_pkg::fsa_axil_req_t  axi_req,
  input wire fsa_pkg::fsa_axil_rsp_t  axi_rsp,
  input wire fsa_pkg::fsa_flash_req_t flash_req,
  input wire logic                    flash_done,
  input wire logic                    self_programming,
  input wire logic                    low_voltage_detector_en,
  input wire logic                    readout_block
);
  import fsa_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // bus answers
  sequence s_wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  property p_b_ans; s_wr_take |=> ##1 axi_rsp.bvalid; endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_r_ans; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_hold;
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // ==========================================================================
  // flash commands
  property p_pulse; flash_req.valid |=> !flash_req.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("command not one cycle");
  property p_self;
    flash_req.valid && self_programming |-> (flash_req.op == FOP_PROGRAM) ?
      flash_req.addr < SECTOR0_BASE :
      (flash_req.op == FOP_ERASE_SECTOR && flash_req.sector != SECTOR_0);
  endproperty
  a_self: assert property (p_self) else $error("sector 0 hit in self mode");
  property p_prot;
    flash_req.valid && readout_block |->
      flash_req.op inside {FOP_ERASE_ALL, FOP_WRITE_OPTION};
  endproperty
  a_prot: assert property (p_prot) else $error("write while protected");
  sequence s_erall;
    flash_req.valid && flash_req.op == FOP_ERASE_ALL && readout_block ##[1:8] flash_done;
  endsequence
  property p_unprot;
    s_erall |-> ##[1:2] (flash_req.valid && flash_req.op == FOP_WRITE_OPTION
      && !flash_req.opt_value);
  endproperty
  a_unprot: assert property (p_unprot) else $error("option not cleared");
  property p_lvd; readout_block |-> !low_voltage_detector_en; endproperty
  a_lvd: assert property (p_lvd) else $error("detector on while protected");
endmodule
bind fsa_flash_guard fsa_guard_chk u_fsa_guard_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .flash_req(flash_req), .flash_done(flash_done),
  .self_programming(self_programming), .low_voltage_detector_en(low_voltage_detector_en),
  .readout_block(readout_block));

// ===== verification/fsa_tool_model.sv
// programming tool and flash array stand-in on the far side of the guard
`timescale 1ns/1ns
module fsa_tool_model
(
  input  wire logic aclk,
  input  wire logic flash_go,
  output logic      flash_done,
  output logic      lclk,
  output logic      ldat,
  input  wire logic dev_oe,
  input  wire logic line
);
  logic [1:0] run_q = 2'h0;
  initial flash_done = 1'b0;
  initial lclk = 1'b0;
  initial ldat = 1'b1;
  // ==========================================================================
  // flash array finishes each operation a few cycles later
  always @(posedge aclk)
  begin
    run_q <= {run_q[0], flash_go};
    flash_done <= run_q[1];
  end
  // link wires
  // clock on its own wire, inside frames and for the reset edges of rst_edges; data bits msb first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #1;
    for (int i = 7; i >= 0; i--)
    begin
      ldat = tx[i];
      rx[i] = line;  // device talks when dev_oe is high
      #3 lclk = 1'b1;
      #3 lclk = 1'b0;
    end
    ldat = ~tx[0];  // released line must not keep the last bit
  endtask
  // tool owns reset; two edges after release fill the link sync
  task automatic rst_edges(input int n);
    repeat (n)
    begin
      #3 lclk = 1'b1;
      #3 lclk = 1'b0;
    end
  endtask
endmodule
